// ==== bench/tb_tbf_cmd.sv ====
`timescale 1ns/1ps
module tb_tbf_cmd;
    logic CORE_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, early_tape_end_warning = 0, off = 0;
    logic [7:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, rd;
    logic PREADY, PSLVERR, FLUSH_REQ, FLUSH_DONE, MARK_REQ, PROG_REQ, PROG_DONE, PROG_OK;
    int n_errors = 0, n_compared = 0;
    tbf_cmd #(.BLINK_CYCLES(4)) dut (.*, .CART_LOADED(off), .EARLY_TAPE_END_WARNING(early_tape_end_warning),
        .PHYS_END(off), .BUS_RESET(off), .MARK_DONE(MARK_REQ), .MARK_COUNT(), .PROG_LEN(),
        .SELF_TEST_START(), .WP_LED(), .ACT_LED());
    tbf_drive_model drv (.clk(CORE_CLK), .rst(RST), .flush_req(FLUSH_REQ),
        .prog_req(PROG_REQ), .flush_done(FLUSH_DONE), .prog_done(PROG_DONE), .prog_ok(PROG_OK));
    initial forever #4 CORE_CLK = ~CORE_CLK;
    task give_verdict;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge CORE_CLK);
        {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        i = 0;
        do begin @(posedge CORE_CLK); i++; end while (PREADY !== 1'b1 && i < 9);
        if (PREADY !== 1'b1) begin n_errors++; give_verdict; end
        rd = PRDATA;
        {PSEL, PENABLE} <= 2'b00;
    endtask
    // Clears done in the same write as the start; done cannot rise that early
    task go(input logic [31:0] c0, c1, c2, input logic lun);
        apb(1, 8'h00, c0);
        apb(1, 8'h04, c1);
        apb(1, 8'h08, c2);
        apb(1, 8'h0c, {29'h0, 1'b1, lun, 1'b1});
    endtask
    task fin(input logic [1:0] e);
        int i;
        i = 0;
        do begin apb(0, 8'h14, 0); i++; end while (rd[1] !== 1'b1 && i < 300);
        if (rd[1] !== 1'b1) begin n_errors++; give_verdict; end
        chk("check and done", e, rd[2:1]);
    endtask
    task wbuf(input logic [2:0] m, input logic [15:0] n, input logic [7:0] b0);
        int i;
        go({16'h0, 5'h0, m, 8'h3b}, {n[15:8], 24'h0}, {24'h0, n[7:0]}, 1'b0);
        for (i = 0; i < n; i++) apb(1, 8'h10, {24'h0, b0 + i[7:0]});
        fin(2'b01);
        apb(1, 8'h1c, 0);
        apb(0, 8'h20, 0);
    endtask
    task t_reject;
        logic [32:0] tab [8] = '{33'h00000013b, 33'h00000033b, 33'h00000063b, 33'h00000073b,
            33'h00001023b, 33'h00100023b, 33'h10000000a, 33'h1000003b8};
        for (int i = 0; i < 8; i++) begin
            go(tab[i][31:0], 0, 0, tab[i][32]);
            fin(2'b11);
            apb(0, 8'h18, 0);
            chk("sense key", 4'h5, rd[19:16]);
        end
        go(32'h050032b8, 0, 0, 1);
        fin(2'b01);
        apb(0, 8'h24, 0);
        chk("element request", 32'h04c80005, rd);
        apb(0, 8'h28, 0);
        chk("unmapped read", 0, rd);
        $display("reject test ended");
    endtask
    task t_buffer;
        wbuf(3'b000, 16'd6, 8'h10);
        chk("first stored byte", 8'h14, rd[7:0]);
        wbuf(3'b010, 16'd1, 8'ha5);
        chk("plain byte", 8'ha5, rd[7:0]);
        wbuf(3'b100, 16'd4096, 8'h00);
        apb(0, 8'h14, 0);
        chk("image held", 1'b1, rd[5]);
        go(32'h0000053b, 0, 0, 0);
        fin(2'b01);
        chk("attentions, image gone", 3'b011, rd[5:3]);
        $display("buffer test ended");
    endtask
    task t_marks;
        go(32'h10, 0, 0, 0);
        fin(2'b01);
        go(32'h110, 2, 0, 0);
        fin(2'b01);
        early_tape_end_warning <= 1'b1;
        go(32'h10, 1, 0, 0);
        fin(2'b11);
        apb(0, 8'h18, 0);
        chk("end sense", 32'h00100002, rd);
        $display("mark test ended");
    endtask
    initial begin
        repeat (5) @(posedge CORE_CLK);
        RST <= 1'b0;
        t_reject;
        t_buffer;
        t_marks;
        give_verdict;
    end
endmodule

// ==== bench/tbf_cmd_monitor.sv ====
`timescale 1ns/1ps
module tbf_cmd_monitor (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Register bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [7:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Drive side
    input wire logic FLUSH_REQ,
    input wire logic FLUSH_DONE,
    input wire logic PROG_REQ,
    input wire logic SELF_TEST_START,
    input wire logic WP_LED,
    input wire logic ACT_LED
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    a_ready_next: assert property (s_setup |=> PREADY) else $error("ready late");
    a_ready_once: assert property (PREADY |=> !PREADY) else $error("ready held");
    a_unmapped_err: assert property ((s_setup and PADDR > 8'h24) |=> PSLVERR)
        else $error("no err");
    a_flush_hold: assert property (FLUSH_REQ && !FLUSH_DONE |=> FLUSH_REQ) else $error("f");
    a_flush_drop: assert property (FLUSH_DONE |=> !FLUSH_REQ) else $error("flush stuck");
    a_leds_pair: assert property (WP_LED == ACT_LED) else $error("leds apart");
    // The lamp register trails the request by two stages, hence three idle cycles
    a_leds_idle: assert property (!PROG_REQ [*3] |-> !WP_LED) else $error("led lit");
    a_test_pulse: assert property (SELF_TEST_START |=> !SELF_TEST_START) else $error("t");
endmodule
bind tbf_cmd tbf_cmd_monitor mon (.*);

// ==== bench/tbf_drive_model.sv ====
`timescale 1ns/1ps
module tbf_drive_model #(
    parameter int DELAY = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Requests
    input wire logic flush_req,
    input wire logic prog_req,
    // Answers
    output logic flush_done,
    output logic prog_done,
    output logic prog_ok
);
    logic [3:0] cnt_r;
    logic fire;
    // Slow answer so the blink divider gets to run while programming
    assign fire = cnt_r == DELAY[3:0];
    assign prog_ok = 1'b1;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 4'h0;
            {flush_done, prog_done} <= 2'b00;
        end else begin
            cnt_r <= (flush_req | prog_req) && !fire ? cnt_r + 4'h1 : 4'h0;
            {flush_done, prog_done} <= {flush_req, prog_req} & {2{fire}};
        end
    end
endmodule

// ==== core/tbf_buf_mem.sv ====
`timescale 1ns/1ps
module tbf_buf_mem #(
    parameter int AW = 14
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// ==== core/tbf_cmd.sv ====
`timescale 1ns/1ps
`include "tbf_consts.svh"
module tbf_cmd import tbf_pkg::*; #(
    parameter int BLINK_CYCLES = `TBF_BLINK_MS * 1000000 / `TBF_CLK_NS
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Drive state
    input wire logic CART_LOADED,
    input wire logic EARLY_TAPE_END_WARNING,
    input wire logic PHYS_END,
    input wire logic BUS_RESET,
    // Tape and flash handshakes
    output logic FLUSH_REQ,
    input wire logic FLUSH_DONE,
    output logic MARK_REQ,
    output logic [23:0] MARK_COUNT,
    input wire logic MARK_DONE,
    output logic PROG_REQ,
    output logic [23:0] PROG_LEN,
    input wire logic PROG_DONE,
    input wire logic PROG_OK,
    output logic SELF_TEST_START,
    // Front panel
    output logic WP_LED,
    output logic ACT_LED
);
    tbf_state_t state_r;
    logic [95:0] cdb_r;
    logic changer_r, go_pend_r, bus_flush_r, done_r, chk_r;
    logic ua_power_r, ua_code_r, eot_r, no_status_r, early_r;
    tbf_sense_t sense_r;
    tbf_es_req_t es_r;
    logic [1:0] es_pages_r;
    logic [23:0] img_len_r, cnt_r;
    logic [`TBF_BUF_AW-1:0] wptr_r, baddr_r;
    logic [2:0] skip_r;
    logic [7:0] mem_rdata;
    logic blink_tick, blink_r;

    // APB decode
    logic setup, acc, wr_acc, mapped;
    assign setup = PSEL & ~PENABLE;
    assign acc = PSEL & PENABLE & PREADY;
    assign wr_acc = acc & PWRITE;
    assign mapped = (PADDR[1:0] == 2'b00) && (PADDR <= `TBF_OFF_ESREQ);

    // CDB field views
    logic [7:0] opcode;
    logic [2:0] mode;
    logic [7:0] buf_id;
    logic [23:0] offset, xfer_len, fm_count;
    logic immed, save_set_mark_select;
    assign opcode = cdb_r[7:0];
    assign mode = cdb_r[10:8];
    assign buf_id = cdb_r[23:16];
    assign offset = {cdb_r[31:24], cdb_r[39:32], cdb_r[47:40]};
    assign xfer_len = {cdb_r[55:48], cdb_r[63:56], cdb_r[71:64]};
    assign immed = cdb_r[8];
    assign save_set_mark_select = cdb_r[9];
    assign fm_count = {cdb_r[23:16], cdb_r[31:24], cdb_r[39:32]};

    // Command validation
    logic in_chgr_set, dl_mode, bad_mode, overrun, bad_wb, bad_fm, bad_et;
    logic [24:0] end_pos;
    logic [3:0] etype;
    assign etype = cdb_r[11:8];
    always_comb begin
        case (opcode)
            8'h07, 8'h12, 8'h15, 8'h1a, 8'ha5, 8'h3c, 8'hb8,
            8'h1c, 8'h17, 8'h03, 8'h16, 8'h1d, 8'h00, 8'h3b: begin
                in_chgr_set = 1'b1; // [RULE18]
            end
            default: begin
                in_chgr_set = 1'b0;
            end
        endcase
    end
    assign bad_mode = !(mode == `TBF_MODE_HDR || mode == `TBF_MODE_DATA ||
                        mode == `TBF_MODE_DL || mode == `TBF_MODE_DLSAVE); // [RULE1]
    assign dl_mode = (mode == `TBF_MODE_DL) || (mode == `TBF_MODE_DLSAVE);
    assign end_pos = {1'b0, offset} + {1'b0, xfer_len};
    assign overrun = end_pos > `TBF_BUF_BYTES; // [RULE3]
    assign bad_wb = bad_mode
        || (buf_id != 8'h00) // [RULE2]
        || overrun
        || (!dl_mode && offset != 24'h0) // [RULE5]
        || (dl_mode && xfer_len != 24'h0 && CART_LOADED) // [RULE7]
        || (dl_mode && xfer_len != 24'h0 && offset != img_len_r) // [RULE8]
        || (dl_mode && (xfer_len & `TBF_CHUNK_MASK) != 24'h0) // [RULE8]
        || (mode == `TBF_MODE_HDR && xfer_len != 24'h0
            && xfer_len < 24'(`TBF_HDR_BYTES));
    assign bad_fm = save_set_mark_select; // [RULE14]
    assign bad_et = (etype == `TBF_ET_IMPEXP) || (etype >= `TBF_ET_RSV_LO); // [RULE20]

    // Buffer writes from the data register
    logic data_wr, mem_we;
    assign data_wr = wr_acc && PADDR == `TBF_OFF_DATA && state_r == ST_DATA;
    assign mem_we = data_wr && skip_r == 3'd0;

    tbf_buf_mem #(
        .AW(`TBF_BUF_AW)
    ) u_mem (
        .clk(CORE_CLK),
        .we(mem_we),
        .waddr(wptr_r),
        .wdata(PWDATA[7:0]),
        .raddr(baddr_r),
        .rdata(mem_rdata)
    );

    tbf_pulse_div #(
        .DIV(BLINK_CYCLES)
    ) u_blink (
        .clk(CORE_CLK),
        .rst(RST),
        .en(state_r == ST_PROG),
        .tick(blink_tick)
    );

    // Completion: one-cycle finish with status and sense
    logic fin, fin_chk, fin_discard;
    tbf_sense_t fin_sense;
    always_comb begin
        fin = 1'b0;
        fin_chk = 1'b0;
        fin_discard = 1'b0;
        fin_sense = '0;
        case (state_r)
            ST_DECODE: begin
                if (changer_r && !in_chgr_set) begin
                    fin = 1'b1; // [RULE23]
                    fin_chk = 1'b1;
                    fin_sense.key = `TBF_KEY_ILLEGAL;
                    fin_sense.asc = `TBF_ASC_INVALID;
                end else if (opcode == `TBF_OP_WRBUF && bad_wb) begin
                    fin = 1'b1;
                    fin_chk = 1'b1;
                    fin_discard = 1'b1; // [RULE9]
                    fin_sense.key = `TBF_KEY_ILLEGAL;
                    fin_sense.asc = `TBF_ASC_INVALID;
                end else if (opcode == `TBF_OP_WFM && bad_fm) begin
                    fin = 1'b1;
                    fin_chk = 1'b1;
                    fin_sense.key = `TBF_KEY_ILLEGAL;
                    fin_sense.asc = `TBF_ASC_INVALID;
                end else if (opcode == `TBF_OP_WFM && PHYS_END) begin
                    fin = 1'b1; // [RULE17]
                    fin_chk = 1'b1;
                    fin_sense.end_of_medium_flag = 1'b1;
                    fin_sense.key = `TBF_KEY_OVERFLOW;
                    fin_sense.asc = `TBF_ASC_EOP;
                    fin_sense.ascq = `TBF_ASCQ_EOP;
                end else if (opcode == `TBF_OP_RES && bad_et) begin
                    fin = 1'b1;
                    fin_chk = 1'b1;
                    fin_sense.key = `TBF_KEY_ILLEGAL;
                    fin_sense.asc = `TBF_ASC_INVALID;
                end else if (opcode != `TBF_OP_WRBUF && opcode != `TBF_OP_WFM) begin
                    fin = 1'b1;
                end else if (opcode == `TBF_OP_WRBUF && xfer_len == 24'h0
                             && mode != `TBF_MODE_DLSAVE) begin
                    fin = 1'b1;
                end
            end
            ST_VERIFY: begin
                if (img_len_r == 24'h0 || (img_len_r & `TBF_CHUNK_MASK) != 24'h0) begin
                    fin = 1'b1; // [RULE10]
                    fin_chk = 1'b1;
                    fin_discard = 1'b1; // [RULE9]
                    fin_sense.key = `TBF_KEY_ILLEGAL;
                    fin_sense.asc = `TBF_ASC_INVALID;
                end
            end
            ST_PROG: begin
                if (PROG_DONE) begin
                    fin = 1'b1;
                    fin_discard = 1'b1;
                    fin_chk = !PROG_OK;
                    fin_sense.key = PROG_OK ? `TBF_KEY_NONE : `TBF_KEY_ILLEGAL;
                end
            end
            ST_FLUSH: begin
                if (FLUSH_DONE && !no_status_r) begin
                    fin = !early_r;
                    if (eot_r) begin
                        fin_chk = 1'b1; // [RULE17]
                        fin_sense.end_of_medium_flag = 1'b1;
                        fin_sense.key = `TBF_KEY_NONE;
                        fin_sense.asc = `TBF_ASC_EOP;
                        fin_sense.ascq = `TBF_ASCQ_EOP;
                    end
                end
            end
            default: begin
                fin = 1'b0;
            end
        endcase
    end

    // Command sequencer
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_r <= ST_IDLE;
            cnt_r <= 24'h0;
            wptr_r <= '0;
            skip_r <= 3'd0;
            no_status_r <= 1'b0;
            early_r <= 1'b0;
            eot_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    no_status_r <= 1'b0;
                    early_r <= 1'b0;
                    eot_r <= 1'b0;
                    if (bus_flush_r) begin
                        no_status_r <= 1'b1;
                        state_r <= ST_FLUSH; // [RULE13]
                    end else if (go_pend_r) begin
                        state_r <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    cnt_r <= xfer_len;
                    wptr_r <= offset[`TBF_BUF_AW-1:0];
                    skip_r <= (mode == `TBF_MODE_HDR) ? `TBF_HDR_BYTES : 3'd0; // [RULE4]
                    eot_r <= EARLY_TAPE_END_WARNING;
                    if (fin) begin
                        state_r <= ST_IDLE;
                    end else if (opcode == `TBF_OP_WRBUF) begin
                        state_r <= (xfer_len == 24'h0) ? ST_VERIFY : ST_DATA;
                    end else begin
                        // Early status only for exactly one mark
                        early_r <= immed && fm_count == 24'h1; // [RULE15]
                        no_status_r <= immed && fm_count == 24'h1;
                        state_r <= (fm_count == 24'h0) ? ST_FLUSH : ST_MARK; // [RULE16]
                    end
                end
                ST_DATA: begin
                    if (data_wr) begin
                        cnt_r <= cnt_r - 24'h1;
                        if (skip_r != 3'd0) begin
                            skip_r <= skip_r - 3'd1; // [RULE4]
                        end else begin
                            wptr_r <= wptr_r + 1'b1; // [RULE5]
                        end
                        if (cnt_r == 24'h1) begin
                            state_r <= (mode == `TBF_MODE_DLSAVE) ? ST_VERIFY : ST_IDLE;
                        end
                    end
                end
                ST_VERIFY: begin
                    state_r <= fin ? ST_IDLE : ST_PROG; // [RULE10]
                end
                ST_PROG: begin
                    if (PROG_DONE) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_MARK: begin
                    eot_r <= eot_r | EARLY_TAPE_END_WARNING;
                    if (MARK_DONE) begin
                        // Immediate single mark skips the flush
                        state_r <= early_r ? ST_IDLE : ST_FLUSH; // [RULE12]
                    end
                end
                ST_FLUSH: begin
                    eot_r <= eot_r | EARLY_TAPE_END_WARNING;
                    if (FLUSH_DONE) begin
                        state_r <= ST_IDLE; // [RULE12]
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Data-mode commands finish when the last byte lands
    logic data_fin;
    assign data_fin = data_wr && cnt_r == 24'h1 && mode != `TBF_MODE_DLSAVE;

    // Held image length; grows per accepted download piece
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            img_len_r <= 24'h0;
        end else if (fin_discard) begin
            img_len_r <= 24'h0; // [RULE9]
        end else if (data_fin && mode == `TBF_MODE_DL) begin
            img_len_r <= img_len_r + xfer_len; // [RULE6]
        end else if (state_r == ST_DATA && data_wr && cnt_r == 24'h1
                     && mode == `TBF_MODE_DLSAVE) begin
            img_len_r <= img_len_r + xfer_len;
        end
    end

    // Status flags; hardware set wins over software clear
    logic ctrl_wr, st_set;
    assign ctrl_wr = wr_acc && PADDR == `TBF_OFF_CTRL;
    assign st_set = fin | data_fin |
                    (state_r == ST_DECODE && !fin && opcode == `TBF_OP_WFM
                     && immed && fm_count == 24'h1);
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            done_r <= 1'b0;
            chk_r <= 1'b0;
            sense_r <= '0;
        end else if (st_set) begin
            done_r <= 1'b1;
            chk_r <= fin_chk;
            sense_r <= fin_sense;
        end else if (ctrl_wr && PWDATA[`TBF_CTRL_CLR_DONE]) begin
            done_r <= 1'b0;
        end
    end

    logic save_ok;
    assign save_ok = state_r == ST_PROG && PROG_DONE && PROG_OK;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ua_power_r <= 1'b0;
            ua_code_r <= 1'b0;
            SELF_TEST_START <= 1'b0;
        end else begin
            SELF_TEST_START <= save_ok; // [RULE11]
            if (save_ok) begin
                ua_power_r <= 1'b1; // [RULE11]
                ua_code_r <= 1'b1;
            end else if (ctrl_wr) begin
                ua_power_r <= ua_power_r & ~PWDATA[`TBF_CTRL_CLR_UAP];
                ua_code_r <= ua_code_r & ~PWDATA[`TBF_CTRL_CLR_UAC];
            end
        end
    end

    // Bus reset and go requests are held until the sequencer takes them
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            bus_flush_r <= 1'b0;
            go_pend_r <= 1'b0;
        end else begin
            if (BUS_RESET) begin
                bus_flush_r <= 1'b1; // [RULE13]
            end else if (state_r == ST_IDLE) begin
                bus_flush_r <= 1'b0;
            end
            if (ctrl_wr && PWDATA[`TBF_CTRL_GO]) begin
                go_pend_r <= 1'b1;
            end else if (state_r == ST_IDLE && !bus_flush_r) begin
                go_pend_r <= 1'b0;
            end
        end
    end

    // Element status request capture
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            es_r <= '0;
            es_pages_r <= 2'd0;
        end else if (state_r == ST_DECODE && opcode == `TBF_OP_RES && !fin_chk) begin
            es_r.unit <= cdb_r[15:13]; // [RULE19]
            es_r.volume_tag_request <= cdb_r[12];
            es_r.etype <= etype;
            es_r.start <= {cdb_r[23:16], cdb_r[31:24]};
            es_r.count <= {cdb_r[39:32], cdb_r[47:40]};
            es_r.alloc <= {cdb_r[63:56], cdb_r[71:64], cdb_r[79:72]};
            es_r.flag <= cdb_r[89];
            es_r.link <= cdb_r[88];
            es_pages_r <= (etype == `TBF_ET_ALL) ? `TBF_ALL_PAGES : 2'd1; // [RULE21]
        end
    end

    // Drive-side handshake outputs
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            FLUSH_REQ <= 1'b0;
            MARK_REQ <= 1'b0;
            MARK_COUNT <= 24'h0;
            PROG_REQ <= 1'b0;
            PROG_LEN <= 24'h0;
            blink_r <= 1'b0;
            WP_LED <= 1'b0;
            ACT_LED <= 1'b0;
        end else begin
            FLUSH_REQ <= state_r == ST_FLUSH && !FLUSH_DONE;
            MARK_REQ <= state_r == ST_MARK && !MARK_DONE; // [RULE16]
            MARK_COUNT <= fm_count;
            PROG_REQ <= state_r == ST_PROG && !PROG_DONE; // [RULE10]
            PROG_LEN <= img_len_r;
            if (state_r != ST_PROG) begin
                blink_r <= 1'b0;
            end else if (blink_tick) begin
                blink_r <= ~blink_r; // [RULE10]
            end
            WP_LED <= blink_r;
            ACT_LED <= blink_r;
        end
    end

    // Register writes
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            cdb_r <= 96'h0;
            changer_r <= 1'b0;
            baddr_r <= '0;
        end else if (wr_acc) begin
            case (PADDR)
                `TBF_OFF_CDB0: cdb_r[31:0] <= PWDATA;
                `TBF_OFF_CDB1: cdb_r[63:32] <= PWDATA;
                `TBF_OFF_CDB2: cdb_r[95:64] <= PWDATA;
                `TBF_OFF_CTRL: changer_r <= PWDATA[`TBF_CTRL_CHGR];
                `TBF_OFF_BADDR: baddr_r <= PWDATA[`TBF_BUF_AW-1:0];
                default: begin
                end
            endcase
        end
    end

    // APB answer: no wait state, read data registered in the setup cycle
    logic [31:0] rd_mux;
    always_comb begin
        case (PADDR)
            `TBF_OFF_CDB0: rd_mux = cdb_r[31:0];
            `TBF_OFF_CDB1: rd_mux = cdb_r[63:32];
            `TBF_OFF_CDB2: rd_mux = cdb_r[95:64];
            `TBF_OFF_CTRL: rd_mux = {30'h0, changer_r, go_pend_r};
            `TBF_OFF_STAT: rd_mux = {21'h0, state_r, 2'b00, img_len_r != 24'h0,
                                     ua_code_r, ua_power_r, chk_r, done_r,
                                     state_r != ST_IDLE};
            `TBF_OFF_SENSE: rd_mux = {11'h0, sense_r};
            `TBF_OFF_BADDR: rd_mux = {18'h0, baddr_r};
            `TBF_OFF_BDATA: rd_mux = {24'h0, mem_rdata};
            // Volume tag flags (bits 31:30) are always zero
            `TBF_OFF_ESREQ: rd_mux = {2'b00, 2'b00, es_pages_r, es_r.unit, // [RULE22]
                                      es_r.volume_tag_request, es_r.etype,
                                      es_r.flag, es_r.link, es_r.start};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0;
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PREADY <= 1'b1;
            PRDATA <= PWRITE ? 32'h0 : rd_mux;
            PSLVERR <= !mapped;
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end
endmodule

// ==== core/tbf_consts.svh ====
`ifndef TBF_CONSTS_SVH
`define TBF_CONSTS_SVH
// Overview of operation
// [RULE1] Accept buffer-write modes 000b, 010b, 100b, 101b only
// [RULE2] Reject buffer-write with nonzero buffer identifier
// [RULE3] Reject transfer running past buffer end
// [RULE4] Header mode drops first four data bytes
// [RULE5] Modes 000b/010b need zero offset
// [RULE6] Download pieces held until save command
// [RULE7] No image download while cartridge loaded
// [RULE8] Pieces consecutive, whole 4K multiples
// [RULE9] Any buffer-write error discards held image
// [RULE10] Save verifies, reprograms, blinks both indicators
// [RULE11] After save: self test, two unit attentions
// [RULE12] Filemarks non-immediate: flush before status
// [RULE13] Bus reset flushes cached blocks and marks
// [RULE14] Save-set mark select must stay zero
// [RULE15] Immediate returns early unless count 0 or >1
// [RULE16] Zero count: good status, still flush
// [RULE17] End warning: check condition, end-of-medium set; an immediate single mark still gets good status
// [RULE18] Changer unit accepts only changer opcodes
// [RULE19] Decode element status request fields
// [RULE20] Element type 0h,1h,2h,4h valid; others rejected
// [RULE21] One status page per element type
// [RULE22] Volume tag flags always reported zero
// [RULE23] Other changer opcodes: illegal request

`define TBF_OFF_CDB0 8'h00
`define TBF_OFF_CDB1 8'h04
`define TBF_OFF_CDB2 8'h08
`define TBF_OFF_CTRL 8'h0c
`define TBF_OFF_DATA 8'h10
`define TBF_OFF_STAT 8'h14
`define TBF_OFF_SENSE 8'h18
`define TBF_OFF_BADDR 8'h1c
`define TBF_OFF_BDATA 8'h20
`define TBF_OFF_ESREQ 8'h24

`define TBF_CTRL_GO 0
`define TBF_CTRL_CHGR 1
`define TBF_CTRL_CLR_DONE 2
`define TBF_CTRL_CLR_UAP 3
`define TBF_CTRL_CLR_UAC 4
`define TBF_CTRL_RST 5'h00

`define TBF_OP_WRBUF 8'h3b
`define TBF_OP_WFM 8'h10
`define TBF_OP_RES 8'hb8

`define TBF_MODE_HDR 3'b000
`define TBF_MODE_DATA 3'b010
`define TBF_MODE_DL 3'b100
`define TBF_MODE_DLSAVE 3'b101

`define TBF_ET_ALL 4'h0
`define TBF_ET_IMPEXP 4'h3
`define TBF_ET_RSV_LO 4'h5
`define TBF_ALL_PAGES 2'd3

`define TBF_KEY_NONE 4'h0
`define TBF_KEY_ILLEGAL 4'h5
`define TBF_KEY_OVERFLOW 4'hd
`define TBF_ASC_INVALID 8'h24
`define TBF_ASC_EOP 8'h00
`define TBF_ASCQ_EOP 8'h02

`define TBF_BUF_AW 14
`define TBF_BUF_BYTES 25'd16384
`define TBF_CHUNK_MASK 24'h000fff
`define TBF_HDR_BYTES 3'd4

`define TBF_CLK_NS 8
`define TBF_BLINK_MS 250
`endif

// ==== core/tbf_pkg.sv ====
package tbf_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DECODE = 3'b001,
        ST_DATA = 3'b011,
        ST_VERIFY = 3'b010,
        ST_PROG = 3'b110,
        ST_MARK = 3'b111,
        ST_FLUSH = 3'b101,
        ST_FIN = 3'b100
    } tbf_state_t;

    typedef struct packed {
        logic [2:0] unit;
        logic volume_tag_request;
        logic [3:0] etype;
        logic [15:0] start;
        logic [15:0] count;
        logic [23:0] alloc;
        logic flag;
        logic link;
    } tbf_es_req_t;

    typedef struct packed {
        logic end_of_medium_flag;
        logic [3:0] key;
        logic [7:0] asc;
        logic [7:0] ascq;
    } tbf_sense_t;
endpackage

// ==== core/tbf_pulse_div.sv ====
`timescale 1ns/1ps
module tbf_pulse_div #(
    parameter int DIV = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    output logic tick
);
    logic [31:0] cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else if (!en) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_r == 32'(DIV - 1)) begin
            cnt_r <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule
